/* inc/cof_trace_defines.vh */
// Purpose: constants for the change-of-flow trace capture block
// Assumes: byte-wide register port, 8-bit offsets
// Notes: definitions only
`ifndef COF_TRACE_DEFINES_VH
`define COF_TRACE_DEFINES_VH

// register offsets
`define OFS_DEBUG_CONTROL_ONE 8'h20
`define OFS_DEBUG_STATE_FLAGS 8'h21
`define OFS_TRACE_CONTROL 8'h22
`define OFS_DEBUG_CONTROL_TWO 8'h23
`define OFS_TRACE_WORD_HIGH 8'h24
`define OFS_TRACE_WORD_LOW 8'h25
`define OFS_TRACE_LINE_COUNT 8'h26
`define OFS_SEQ_CONTROL 8'h27
`define OFS_CMP_CONTROL 8'h28
`define OFS_CMP_ADDR_HIGH 8'h29
`define OFS_CMP_ADDR_MID 8'h2a
`define OFS_CMP_ADDR_LOW 8'h2b
`define OFS_TRACE_READ_INDEX 8'h2c
`define OFS_TRACE_WORD_EXT 8'h2d
`define OFS_IRQ_STATUS 8'h2e
`define OFS_IRQ_MASK 8'h2f

// trace control fields and register write masks
`define TCR_SOURCE_BIT 6
`define TCR_MODE_HI 3
`define TCR_MODE_LO 2
`define TCR_ALIGN_BIT 0
`define TCR_WRITE_MASK 8'h4d
`define CTL1_WRITE_MASK 8'h1b
`define CTL2_WRITE_MASK 8'h03
`define CMP_A_WRITE_MASK 8'hff
`define CMP_B_WRITE_MASK 8'hfd
`define CMP_C_WRITE_MASK 8'h3d

// comparator select codes in control one
`define CMP_SEL_A 2'h0
`define CMP_SEL_B 2'h1
`define CMP_SEL_C 2'h2

// trace modes
`define MODE_NORMAL 2'h0

// change-of-flow classes from the core
`define COF_NONE 3'h0
`define COF_COND_BRANCH 3'h1
`define COF_INDEXED_JUMP 3'h2
`define COF_RETURN 3'h3
`define COF_INTERRUPT 3'h4
`define COF_UNCOND 3'h5

// buffer geometry
`define LINE_AW 6
`define LINE_COUNT_MAX 7'h40
`define LINE_LAST 6'h3f
`define ADDR_W 18
`define ENTRY_W 20

// reset values
`define RST_BYTE 8'h00

// interrupt status bits
`define IRQ_BIT_STORED 0
`define IRQ_BIT_WRAP 1

`endif

/* verilog/cof_trace.v */
// Purpose: capture change-of-flow addresses of the core into a circular trace buffer
// Assumes: core presents one retired instruction per cycle with its flow class
// Notes: only normal trace mode records; the other modes are kept selectable but idle
//   comparator and sequencer registers store values; no match logic sits behind them
//   lines not yet written since arming read back as zero
//
// Functional notes
// - Four trace modes exist, chosen by the mode-select field of the trace control register.
// - Entries are recorded only while the trace-source enable bit is set; a held coincident vector is still written after it clears.
// - Once all lines are used the writer wraps to line zero, overwriting the oldest entries.
// - Normal mode stores only change-of-flow addresses and nothing else.
// - Taken conditional branches of every flavour store their source address.
// - Indexed jump, jump-to-subroutine and call store their destination address.
// - Returns from interrupt, subroutine and call store their destination address.
// - A taken interrupt stores its vector address, except background debug vectors.
// - Unconditional branches, branch-to-subroutine, background entry and non-indexed jumps store nothing.
// - Each entry holds the full 18-bit address plus a source/destination bit.
// - A destination entry is written at completion; a coincident interrupt vector follows it.
// - The block has no external pins; inputs come from core buses, outputs go to registers and the irq_o interrupt line.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/100ps
`include "cof_trace_defines.vh"

module cof_trace (
  // clock and reset
  input wire clk_i,
  input wire reset_n_i,
  // core retirement bus
  input wire retire_i,
  input wire [2:0] cof_class_i,
  input wire branch_taken_i,
  input wire [17:0] source_addr_i,
  input wire [17:0] dest_addr_i,
  input wire irq_taken_i,
  input wire irq_is_background_i,
  input wire [17:0] vector_addr_i,
  // register port
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  // interrupt
  output reg irq_o
);

  // control registers
  reg [7:0] debug_control_one_reg;
  reg [7:0] trace_control_reg;
  reg [7:0] debug_control_two_reg;
  reg [7:0] irq_mask_reg;
  reg [1:0] irq_status_reg;
  reg [1:0] irq_status_next;
  // buffer state
  reg [`ENTRY_W-1:0] line_mem [0:63];
  reg [`LINE_AW-1:0] wr_ptr_reg;
  reg [6:0] valid_count_reg;
  reg full_reg;
  reg [`LINE_AW-1:0] rd_index_reg;
  reg [`ENTRY_W-1:0] read_word;
  // pending vector entry that trails an instruction entry
  reg vec_pend_reg;
  reg [17:0] vec_addr_reg;
  // next values of the buffer state
  reg [`LINE_AW-1:0] wr_ptr_next;
  reg [6:0] valid_count_next;
  reg full_next;
  reg vec_pend_next;
  reg [17:0] vec_addr_next;
  // lines written since the buffer was last armed
  reg [63:0] line_valid_reg;
  // comparator and sequencer storage
  reg [3:0] seq_ctl_reg;
  reg [7:0] cmp_a_ctl_reg;
  reg [7:0] cmp_b_ctl_reg;
  reg [7:0] cmp_c_ctl_reg;
  reg [17:0] cmp_a_addr_reg;
  reg [17:0] cmp_b_addr_reg;
  reg [17:0] cmp_c_addr_reg;
  // window onto the comparator picked by control one
  reg [7:0] cmp_ctl_view;
  reg [17:0] cmp_addr_view;
  // read data for the next cycle
  reg [7:0] rdata_next;

  wire [1:0] trace_mode = trace_control_reg[`TCR_MODE_HI:`TCR_MODE_LO];
  wire trace_on = trace_control_reg[`TCR_SOURCE_BIT];
  wire normal_on = trace_on && (trace_mode == `MODE_NORMAL);
  // comparator picked for register access
  wire [1:0] cmp_sel = debug_control_one_reg[1:0];
  // enable written from 0 to 1 restarts the buffer
  wire rearm_now = wr_i && addr_i == `OFS_TRACE_CONTROL &&
                   wdata_i[`TCR_SOURCE_BIT] && !trace_on;

  // classify the retiring instruction; unlisted classes never record
  reg cof_store;
  reg cof_is_dest;
  reg [17:0] cof_addr;
  always @* begin
    cof_store = 1'b0;
    cof_is_dest = 1'b0;
    cof_addr = source_addr_i;
    case (cof_class_i)
      `COF_COND_BRANCH: begin
        cof_store = branch_taken_i;
        cof_addr = source_addr_i;
      end
      `COF_INDEXED_JUMP: begin
        cof_store = 1'b1;
        cof_is_dest = 1'b1;
        cof_addr = dest_addr_i;
      end
      `COF_RETURN: begin
        cof_store = 1'b1;
        cof_is_dest = 1'b1;
        cof_addr = dest_addr_i;
      end
      `COF_UNCOND: cof_store = 1'b0;
      default: cof_store = 1'b0;
    endcase
  end

  wire ins_event = normal_on && retire_i && cof_store;
  wire irq_event = normal_on && irq_taken_i && !irq_is_background_i;
  // instruction entry has priority; a vector in the same cycle waits for the next cycle without an instruction entry
  wire vec_now = vec_pend_reg || (irq_event && !ins_event);
  wire store_now = ins_event || vec_now;
  wire [`ENTRY_W-1:0] entry_now = ins_event ? {1'b0, cof_is_dest, cof_addr} :
                                  {1'b0, 1'b1, (vec_pend_reg ? vec_addr_reg : vector_addr_i)};

  // buffer write at the write pointer; pointer and count advance in the state block below
  always @(posedge clk_i) begin
    if (store_now) begin
      line_mem[wr_ptr_reg] <= entry_now;
    end
  end

  // valid map; keeps a read of a never-written line from showing junk
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      line_valid_reg <= 64'h0000000000000000;
    end else if (rearm_now) begin
      line_valid_reg <= 64'h0000000000000000;
    end else if (store_now) begin
      line_valid_reg[wr_ptr_reg] <= 1'b1;
    end
  end

  // next pointer, count and wrap state
  always @* begin
    wr_ptr_next = wr_ptr_reg;
    valid_count_next = valid_count_reg;
    full_next = full_reg;
    if (rearm_now) begin
      // rearming tracing restarts the buffer
      wr_ptr_next = 6'h00;
      valid_count_next = 7'h00;
      full_next = 1'b0;
    end else if (store_now) begin
      wr_ptr_next = wr_ptr_reg + 6'h01;
      if (valid_count_reg != `LINE_COUNT_MAX) begin
        // count saturates once every line holds an entry
        valid_count_next = valid_count_reg + 7'h01;
      end
      if (wr_ptr_reg == `LINE_LAST) begin
        full_next = 1'b1;
      end
    end
  end

  // coincident vector is held until a cycle with no instruction entry
  always @* begin
    vec_pend_next = vec_pend_reg;
    vec_addr_next = vec_addr_reg;
    if (ins_event && irq_event) begin
      vec_pend_next = 1'b1;
      vec_addr_next = vector_addr_i;
    end else if (vec_pend_reg && !ins_event) begin
      vec_pend_next = 1'b0;
    end
  end

  // pointer, count, wrap and pending vector state
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr_reg <= 6'h00;
      valid_count_reg <= 7'h00;
      full_reg <= 1'b0;
      vec_pend_reg <= 1'b0;
      vec_addr_reg <= 18'h00000;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      valid_count_reg <= valid_count_next;
      full_reg <= full_next;
      vec_pend_reg <= vec_pend_next;
      vec_addr_reg <= vec_addr_next;
    end
  end

  // software-visible registers
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      debug_control_one_reg <= `RST_BYTE;
      trace_control_reg <= `RST_BYTE;
      debug_control_two_reg <= `RST_BYTE;
      irq_mask_reg <= `RST_BYTE;
      rd_index_reg <= 6'h00;
    end else if (wr_i) begin
      case (addr_i)
        `OFS_DEBUG_CONTROL_ONE: debug_control_one_reg <= wdata_i & `CTL1_WRITE_MASK;
        `OFS_TRACE_CONTROL: trace_control_reg <= wdata_i & `TCR_WRITE_MASK;
        `OFS_DEBUG_CONTROL_TWO: debug_control_two_reg <= wdata_i & `CTL2_WRITE_MASK;
        `OFS_TRACE_READ_INDEX: rd_index_reg <= wdata_i[5:0];
        `OFS_IRQ_MASK: irq_mask_reg <= {6'h00, wdata_i[1:0]};
        default: rd_index_reg <= rd_index_reg;
      endcase
    end else if (rd_i && addr_i == `OFS_TRACE_WORD_LOW) begin
      rd_index_reg <= rd_index_reg + 6'h01; // low byte read steps to next line
    end
  end

  // comparator and sequencer registers; control one picks the comparator seen
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      seq_ctl_reg <= 4'h0;
      cmp_a_ctl_reg <= `RST_BYTE;
      cmp_b_ctl_reg <= `RST_BYTE;
      cmp_c_ctl_reg <= `RST_BYTE;
      cmp_a_addr_reg <= 18'h00000;
      cmp_b_addr_reg <= 18'h00000;
      cmp_c_addr_reg <= 18'h00000;
    end else if (wr_i) begin
      case (addr_i)
        `OFS_SEQ_CONTROL: seq_ctl_reg <= wdata_i[3:0];
        // control byte; reserved bits of each comparator stay zero
        `OFS_CMP_CONTROL: begin
          case (cmp_sel)
            `CMP_SEL_A: cmp_a_ctl_reg <= wdata_i & `CMP_A_WRITE_MASK;
            `CMP_SEL_B: cmp_b_ctl_reg <= wdata_i & `CMP_B_WRITE_MASK;
            `CMP_SEL_C: cmp_c_ctl_reg <= wdata_i & `CMP_C_WRITE_MASK;
            // select three has no comparator behind it, the write is dropped
            default: cmp_a_ctl_reg <= cmp_a_ctl_reg;
          endcase
        end
        // top two bits of the 18-bit compare address
        `OFS_CMP_ADDR_HIGH: begin
          case (cmp_sel)
            `CMP_SEL_A: cmp_a_addr_reg[17:16] <= wdata_i[1:0];
            `CMP_SEL_B: cmp_b_addr_reg[17:16] <= wdata_i[1:0];
            `CMP_SEL_C: cmp_c_addr_reg[17:16] <= wdata_i[1:0];
            default: cmp_a_addr_reg <= cmp_a_addr_reg;
          endcase
        end
        // middle byte of the compare address
        `OFS_CMP_ADDR_MID: begin
          case (cmp_sel)
            `CMP_SEL_A: cmp_a_addr_reg[15:8] <= wdata_i;
            `CMP_SEL_B: cmp_b_addr_reg[15:8] <= wdata_i;
            `CMP_SEL_C: cmp_c_addr_reg[15:8] <= wdata_i;
            default: cmp_a_addr_reg <= cmp_a_addr_reg;
          endcase
        end
        // low byte of the compare address
        `OFS_CMP_ADDR_LOW: begin
          case (cmp_sel)
            `CMP_SEL_A: cmp_a_addr_reg[7:0] <= wdata_i;
            `CMP_SEL_B: cmp_b_addr_reg[7:0] <= wdata_i;
            `CMP_SEL_C: cmp_c_addr_reg[7:0] <= wdata_i;
            default: cmp_a_addr_reg <= cmp_a_addr_reg;
          endcase
        end
        default: seq_ctl_reg <= seq_ctl_reg;
      endcase
    end
  end

  // selected comparator as software sees it; the unused select reads zero
  // one view feeds both the control and the address reads
  always @* begin
    cmp_ctl_view = 8'h00;
    cmp_addr_view = 18'h00000;
    case (cmp_sel)
      `CMP_SEL_A: begin
        cmp_ctl_view = cmp_a_ctl_reg;
        cmp_addr_view = cmp_a_addr_reg;
      end
      `CMP_SEL_B: begin
        cmp_ctl_view = cmp_b_ctl_reg;
        cmp_addr_view = cmp_b_addr_reg;
      end
      `CMP_SEL_C: begin
        cmp_ctl_view = cmp_c_ctl_reg;
        cmp_addr_view = cmp_c_addr_reg;
      end
      default: begin
        cmp_ctl_view = 8'h00;
        cmp_addr_view = 18'h00000;
      end
    endcase
  end

  // sticky events; a new event wins over the read-clear
  always @* begin
    irq_status_next = irq_status_reg;
    if (rd_i && addr_i == `OFS_IRQ_STATUS) begin
      irq_status_next = 2'h0;
    end
    if (store_now) begin
      irq_status_next[`IRQ_BIT_STORED] = 1'b1;
    end
    if (store_now && wr_ptr_reg == 6'h3f) begin
      irq_status_next[`IRQ_BIT_WRAP] = 1'b1;
    end
  end

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_status_reg <= 2'h0;
      irq_o <= 1'b0;
    end else begin
      irq_status_reg <= irq_status_next;
      irq_o <= |(irq_status_next & irq_mask_reg[1:0]);
    end
  end

  // read mux, data one cycle after the strobe; unmapped reads zero
  always @* begin
    read_word = {`ENTRY_W{1'b0}};
    if (line_valid_reg[rd_index_reg]) begin
      read_word = line_mem[rd_index_reg];
    end
  end

  // read selection; sequencer control and match flags share an offset,
  // reads return the control since no match flag can ever be set
  always @* begin
    rdata_next = 8'h00;
    if (rd_i) begin
      case (addr_i)
        `OFS_DEBUG_CONTROL_ONE: rdata_next = debug_control_one_reg;
        `OFS_DEBUG_STATE_FLAGS: rdata_next = {full_reg, 7'h00};
        `OFS_TRACE_CONTROL: rdata_next = trace_control_reg;
        `OFS_DEBUG_CONTROL_TWO: rdata_next = debug_control_two_reg;
        `OFS_TRACE_WORD_HIGH: rdata_next = read_word[15:8];
        `OFS_TRACE_WORD_LOW: rdata_next = read_word[7:0];
        `OFS_TRACE_LINE_COUNT: rdata_next = {full_reg, valid_count_reg};
        `OFS_SEQ_CONTROL: rdata_next = {4'h0, seq_ctl_reg};
        `OFS_CMP_CONTROL: rdata_next = cmp_ctl_view;
        `OFS_CMP_ADDR_HIGH: rdata_next = {6'h00, cmp_addr_view[17:16]};
        `OFS_CMP_ADDR_MID: rdata_next = cmp_addr_view[15:8];
        `OFS_CMP_ADDR_LOW: rdata_next = cmp_addr_view[7:0];
        `OFS_TRACE_READ_INDEX: rdata_next = {2'h0, rd_index_reg};
        `OFS_TRACE_WORD_EXT: rdata_next = {4'h0, read_word[19:16]};
        `OFS_IRQ_STATUS: rdata_next = {6'h00, irq_status_reg};
        `OFS_IRQ_MASK: rdata_next = irq_mask_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // registered so the port stands for exactly the one cycle after the strobe
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= rdata_next;
    end
  end

  // no pins leave this block; everything lives on core buses, registers and the irq_o interrupt line
endmodule // cof_trace

/* verification/cof_trace_assertions.sv */
// Purpose: port-level checks for the trace capture block
// Assumes: read data stand only in the cycle after the read strobe
// Notes: ctl_reg mirrors trace control writes so the quiet check knows the mode
`timescale 1ns/100ps
module cof_trace_chk (
  // clock and reset
  input wire clk_i,
  input wire reset_n_i,
  // core events
  input wire retire_i,
  input wire irq_taken_i,
  // register port and interrupt
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] rdata_o,
  input wire irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  logic [7:0] ctl_reg;
  wire rec_on = ctl_reg[6] && ctl_reg[3:2] == 2'h0;
  // shadow of the control byte, raw written value is enough here
  always @(posedge clk_i or negedge reset_n_i)
    if (!reset_n_i) ctl_reg <= 8'h00;
    else if (wr_i && addr_i == 8'h22) ctl_reg <= wdata_i;
  AST_RD_IDLE: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data not idle");
  AST_CNT_MAX: assert property ($past(rd_i && addr_i == 8'h26) |-> rdata_o[6:0] <= 7'h40)
    else $error("line count above 64");
  AST_FULL_CNT: assert property ($past(rd_i && addr_i == 8'h26) && rdata_o[7]
    |-> rdata_o[6:0] == 7'h40) else $error("full without 64 lines");
  AST_UNMAPPED: assert property ($past(rd_i && addr_i == 8'h30) |-> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  AST_EXT_BITS: assert property ($past(rd_i && addr_i == 8'h2d) |-> rdata_o[7:3] == 5'h00)
    else $error("entry extension bits wrong");
  AST_TCR_BACK: assert property ((wr_i && addr_i == 8'h22) ##1 !wr_i ##1 (rd_i && addr_i == 8'h22)
    |=> rdata_o == ($past(wdata_i, 3) & 8'h4d)) else $error("control readback");
  AST_QUIET: assert property ($rose(irq_o) && !$past(wr_i) && !$past(wr_i, 2)
    |-> $past(rec_on) || $past(rec_on, 2)) else $error("entry while disabled");
  AST_STATUS_CLEAR: assert property ((!retire_i && !irq_taken_i)[*3] ##0 (rd_i && addr_i == 8'h2e)
    ##1 (!retire_i && !irq_taken_i && !wr_i) |=> !irq_o) else $error("irq not cleared");
endmodule // cof_trace_chk
bind cof_trace cof_trace_chk u_chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .retire_i(retire_i),
  .irq_taken_i(irq_taken_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .irq_o(irq_o));

/* verification/core_model.sv */
// Purpose: core retirement bus model
// Assumes: one completion per go cycle
// Notes: released address lines show the inverse of the last commanded address
`timescale 1ns/100ps
module core_model (
  // command from bench
  input wire clk_i,
  input wire go_i,
  input wire [2:0] cls_i,
  input wire tk_i,
  input wire irq_i,
  input wire bg_i,
  input wire [17:0] a_i,
  // core bus
  output logic retire_o,
  output logic [2:0] cof_class_o,
  output logic branch_taken_o,
  output logic irq_taken_o,
  output logic irq_is_background_o,
  output logic [17:0] source_addr_o,
  output logic [17:0] dest_addr_o,
  output logic [17:0] vector_addr_o
);
  logic [17:0] last_reg = 18'h00000;
  // kept so idle lines never look like a stale valid address
  always @(posedge clk_i) if (go_i) last_reg <= a_i;
  // events only in go cycles; the address lines show ~last_reg otherwise
  always @* begin
    retire_o = go_i && cls_i != 3'h0;
    cof_class_o = go_i ? cls_i : 3'h0;
    branch_taken_o = go_i && tk_i;
    irq_taken_o = go_i && irq_i;
    irq_is_background_o = go_i && bg_i;
    source_addr_o = go_i ? a_i : ~last_reg;
    dest_addr_o = go_i ? a_i ^ 18'h2aaaa : ~last_reg;
    vector_addr_o = go_i ? a_i ^ 18'h15555 : ~last_reg;
  end
endmodule // core_model

/* verification/testbench.sv */
// Purpose: self-checking bench for the trace capture block
// Assumes: reads answer one cycle later
// Notes: expected entries are queued as events are sent
`timescale 1ns/100ps
module testbench;
  logic clk_i = 0, reset_n_i = 0, wr_i = 0, rd_i = 0, go = 0, tk = 0, irq = 0, bg = 0;
  logic rd_d = 0, rec = 0;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00;
  logic [2:0] cls = 3'h0;
  logic [17:0] a = 18'h00000;
  wire retire_i, branch_taken_i, irq_taken_i, irq_is_background_i, irq_o;
  wire [2:0] cof_class_i;
  wire [17:0] source_addr_i, dest_addr_i, vector_addr_i;
  wire [7:0] rdata_o;
  logic [15:0] rq[$];
  logic [19:0] lines[$];
  logic [5:0] tab[8] = '{6'h0c, 6'h08, 6'h28, 6'h10, 6'h18, 6'h02, 6'h03, 6'h12};
  int fail_count = 0, n_tests = 0;
  always #4 clk_i = ~clk_i;
  core_model u_core_model (.clk_i(clk_i), .go_i(go), .cls_i(cls), .tk_i(tk), .irq_i(irq),
    .bg_i(bg), .a_i(a), .retire_o(retire_i), .cof_class_o(cof_class_i),
    .branch_taken_o(branch_taken_i), .irq_taken_o(irq_taken_i),
    .irq_is_background_o(irq_is_background_i), .source_addr_o(source_addr_i),
    .dest_addr_o(dest_addr_i), .vector_addr_o(vector_addr_i));
  cof_trace u_cof_trace (.clk_i(clk_i), .reset_n_i(reset_n_i), .retire_i(retire_i),
    .cof_class_i(cof_class_i), .branch_taken_i(branch_taken_i), .source_addr_i(source_addr_i),
    .dest_addr_i(dest_addr_i), .irq_taken_i(irq_taken_i),
    .irq_is_background_i(irq_is_background_i), .vector_addr_i(vector_addr_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .irq_o(irq_o));
  task automatic chk(string what, logic [7:0] e, logic [7:0] s);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic wr(logic [7:0] ad, logic [7:0] d);
    @(posedge clk_i);
    {addr_i, wdata_i, wr_i} <= {ad, d, 1'b1};
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(logic [7:0] ad, logic [7:0] e);
    @(posedge clk_i);
    {addr_i, rd_i} <= {ad, 1'b1};
    rq.push_back({ad, e});
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask
  // one core event; expected entries noted before it is sent
  task automatic ev(logic [5:0] t);
    logic [17:0] v;
    v = 18'($urandom);
    if (rec && t[5:2] == 4'h3) lines.push_back({2'b00, v});
    if (rec && (t[5:3] == 3'h2 || t[5:3] == 3'h3)) lines.push_back({2'b01, v ^ 18'h2aaaa});
    if (rec && t[1:0] == 2'b10) lines.push_back({2'b01, v ^ 18'h15555});
    @(posedge clk_i);
    {go, cls, tk, irq, bg, a} <= {1'b1, t, v};
    @(posedge clk_i);
    go <= 1'b0;
  endtask
  task automatic readback(int cnt);
    wr(8'h2c, 8'h00);
    for (int k = 0; k < cnt; k++) begin
      rd(8'h2d, {4'h0, lines[k][19:16]});
      rd(8'h24, lines[k][15:8]);
      rd(8'h25, lines[k][7:0]);
    end
  endtask
  task automatic irq_is(logic e);
    repeat (3) @(posedge clk_i);
    chk("irq_o", {7'h00, e}, {7'h00, irq_o});
  endtask
  // oldest read note is compared in the cycle its data stand
  always @(posedge clk_i) begin
    if (rd_d) chk($sformatf("rdata_o at %h", rq[0][15:8]), rq[0][7:0], rdata_o);
    if (rd_d) void'(rq.pop_front());
    rd_d <= rd_i;
  end
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #(20000 * 8);
    fail_count++;
    close_out();
  end
  initial begin
    void'($urandom(32'h6efc));
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd(8'h22, 8'h00);
    rd(8'h30, 8'h00);
    rd(8'h24, 8'h00);
    wr(8'h28, 8'hff);
    rd(8'h28, 8'hff);
    wr(8'h20, 8'h01);
    wr(8'h28, 8'hff);
    rd(8'h28, 8'hfd);
    wr(8'h20, 8'h00);
    wr(8'h2f, 8'h03);
    wr(8'h22, 8'hff);
    rd(8'h22, 8'h4d);
    ev(6'h0c);
    wr(8'h22, 8'h00);
    ev(6'h0c);
    rd(8'h26, 8'h00);
    $display("mode and enable test done");
    wr(8'h22, 8'h40);
    rec = 1'b1;
    for (int k = 0; k < 8; k++) ev(tab[k]);
    irq_is(1'b1);
    rd(8'h26, 8'h06);
    readback(6);
    rd(8'h2e, 8'h01);
    irq_is(1'b0);
    $display("flow class test done");
    wr(8'h22, 8'h00);
    wr(8'h22, 8'h40);
    lines.delete();
    repeat (65) ev(6'h0c);
    rd(8'h26, 8'hc0);
    rd(8'h21, 8'h80);
    rd(8'h2e, 8'h03);
    lines = {lines[64]};
    readback(1);
    $display("wrap test done");
    wr(8'h2f, 8'h00);
    ev(6'h0c);
    irq_is(1'b0);
    wr(8'h2f, 8'h03);
    irq_is(1'b1);
    $display("interrupt mask test done");
    repeat (3) @(posedge clk_i);
    close_out();
  end
endmodule // testbench
